// ==== include/carrier_timer_pkg.sv ====
// Register map, field positions, reset values and modes of the carrier timer
package carrier_timer_pkg;
	localparam logic [11:0] MODE_OFF = 12'h000;
	localparam logic [11:0] PERIOD_OFF = 12'h004;
	localparam logic [11:0] DUTY_OFF = 12'h008;
	localparam logic [11:0] CARRIER_OFF = 12'h00c;
	localparam logic [11:0] STATUS_OFF = 12'h010;
	localparam int RUN_BIT = 7;
	localparam int CKS_LO = 4;
	localparam int CKS_HI = 6;
	localparam int MODE_LO = 2;
	localparam int MODE_HI = 3;
	localparam int LEVEL_BIT = 1;
	localparam int OUTEN_BIT = 0;
	localparam int REMOTE_BIT = 2;
	localparam int STAGED_BIT = 1;
	localparam int ACTIVE_BIT = 0;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] PERIOD_RST = 8'h00;
	localparam logic [7:0] DUTY_RST = 8'h00;
	localparam logic [2:0] CARRIER_RST = 3'h0;
	localparam int DUTY_LOAD_CLKS = 3;
	localparam logic [1:0] MODE_INTERVAL = 2'h0;
	localparam logic [1:0] MODE_CARRIER = 2'h1;
	localparam logic [1:0] MODE_PWM = 2'h2;
	localparam logic [15:0] DIV_1 = 16'h0000;
	localparam logic [15:0] DIV_4 = 16'h0003;
	localparam logic [15:0] DIV_16 = 16'h000f;
	localparam logic [15:0] DIV_64 = 16'h003f;
	localparam logic [15:0] DIV_4096 = 16'h0fff;
	localparam logic [15:0] DIV_32768 = 16'h7fff;
endpackage : carrier_timer_pkg

// ==== core/count_clock_divider.sv ====
// Count clock enable generator selectable by the clock select field
`timescale 1ns/1ps
module count_clock_divider (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [2:0] sel,
	output logic tick
);
	import carrier_timer_pkg::*;
	logic [15:0] cnt_r;
	logic [15:0] limit;

	// Divide ratio per selection; low-speed sources share the main clock here
	always_comb begin
		case (sel)
			3'h0: limit = DIV_1;
			3'h1: limit = DIV_4;
			3'h2: limit = DIV_16;
			3'h3: limit = DIV_64;
			3'h4: limit = DIV_4096;
			3'h5: limit = DIV_64;
			3'h6: limit = DIV_32768;
			default: limit = DIV_1;
		endcase
	end

	// Free running prescaler, one-cycle tick at wrap
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_r <= 16'h0000;
			tick <= 1'b0;
		end else if (cnt_r >= limit) begin
			cnt_r <= 16'h0000;
			tick <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 16'h0001;
			tick <= 1'b0;
		end
	end
endmodule : count_clock_divider

// ==== core/carrier_timer.sv ====
// Eight-bit compare timer with interval, PWM and carrier modes behind APB
`timescale 1ns/1ps
// Notes on behaviour
// - Counter skips the first count clock after run is set and starts advancing on the second.
// - Interval match clears counter, toggles output, pulses match interrupt.
// - Stopping interval mode returns interrupt and output to default.
// - PWM period match clears, interrupts, drives active, selects duty compare.
// - PWM duty match drives inactive, selects period, no clear, no interrupt.
// - PWM period is N+1 count clocks, duty M+1 over N+1.
// - Duty writes latch, apply at next old match after three count clocks.
// - PWM start skips first count clock, output inactive until period match.
// - Stopping PWM clears interrupt state and forces output inactive.
// - Carrier: period sets low width, duty sets high width.
// - Output from remote enable and gate: 00,10 low, 01 high, 11 carrier.
// - Gate is master/slave: staged bit read-write, active bit read-only.
// - Partner interrupt is synchronised into an internal transfer strobe.
// - Staged bit copies to active bit on second count clock after strobe.
// - The transfer strobe stays internal, never an interrupt source.
// - Interval between match interrupts is N+1 count clocks, outside carrier mode.
// - Carrier match inverts carrier, clears, interrupts, swaps compare.
module carrier_timer (
	input wire logic mclk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic partner_counter_interrupt,
	output logic timer_output_pin,
	output logic match_interrupt
);
	import carrier_timer_pkg::*;

	logic [7:0] mode_r;
	logic [7:0] period_compare;
	logic [7:0] duty_compare;
	logic [7:0] duty_latch_r;
	logic duty_pend_r;
	logic [1:0] duty_age_r;
	logic remote_output_enable;
	logic staged_gate_bit;
	logic active_gate_bit;
	logic [7:0] count_r;
	logic skip_r;
	logic use_duty_r;
	logic out_r;
	logic carrier_r;
	logic tick;
	logic part_s1_r;
	logic part_s2_r;
	logic part_cc_r;
	logic strobe_r;
	logic [1:0] xfer_r;
	logic wr_en;
	logic rd_en;
	logic mapped;
	logic count_run_bit;
	logic [1:0] mode;
	logic [7:0] cmp_val;
	logic hit;

	assign count_run_bit = mode_r[RUN_BIT];
	assign mode = mode_r[MODE_HI:MODE_LO];
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;
	assign mapped = (paddr == MODE_OFF) || (paddr == PERIOD_OFF) || (paddr == DUTY_OFF)
		|| (paddr == CARRIER_OFF) || (paddr == STATUS_OFF);

	// Count clock enable from the selected prescaler
	count_clock_divider u_div (
		.mclk(mclk),
		.rst(rst),
		.sel(mode_r[CKS_HI:CKS_LO]),
		.tick(tick)
	);

	// APB answers in the access cycle: pready high, error on unmapped address
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
		end
	end

	// Read data captured in setup so it stands in the access phase
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en) begin
			case (paddr)
				MODE_OFF: prdata <= {24'h00_0000, mode_r};
				PERIOD_OFF: prdata <= {24'h00_0000, period_compare};
				DUTY_OFF: prdata <= {24'h00_0000, duty_pend_r ? duty_latch_r : duty_compare};
				CARRIER_OFF: prdata <= {29'h0000_0000, remote_output_enable,
					staged_gate_bit, active_gate_bit};
				STATUS_OFF: prdata <= {23'h00_0000, use_duty_r, count_r};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Mode and period compare registers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mode_r <= MODE_RST;
			period_compare <= PERIOD_RST;
		end else if (wr_en && !pslverr) begin
			if (paddr == MODE_OFF)
				mode_r <= pwdata[7:0];
			if (paddr == PERIOD_OFF)
				period_compare <= pwdata[7:0];
		end
	end

	// Carrier control: staged gate and remote enable writable, active gate not
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			remote_output_enable <= CARRIER_RST[REMOTE_BIT];
			staged_gate_bit <= CARRIER_RST[STAGED_BIT];
		end else if (wr_en && paddr == CARRIER_OFF) begin
			remote_output_enable <= pwdata[REMOTE_BIT];
			staged_gate_bit <= pwdata[STAGED_BIT];
		end
	end

	// Duty compare: loaded directly while stopped, latched while running
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			duty_compare <= DUTY_RST;
			duty_latch_r <= DUTY_RST;
			duty_pend_r <= 1'b0;
			duty_age_r <= 2'h0;
		end else if (wr_en && paddr == DUTY_OFF) begin
			duty_latch_r <= pwdata[7:0];
			duty_age_r <= 2'h0;
			duty_pend_r <= count_run_bit;
			if (!count_run_bit)
				duty_compare <= pwdata[7:0];
		end else if (duty_pend_r && tick) begin
			if (hit && use_duty_r && duty_age_r >= 2'(DUTY_LOAD_CLKS - 1)) begin
				duty_compare <= duty_latch_r;
				duty_pend_r <= 1'b0;
			end else if (duty_age_r != 2'h3) begin
				duty_age_r <= duty_age_r + 2'h1;
			end
		end
	end

	// Compare target selection and match detect
	assign cmp_val = (use_duty_r && mode != MODE_INTERVAL) ? duty_compare : period_compare;
	assign hit = count_run_bit && !skip_r && (count_r == cmp_val);

	// Counter, compare select and start skip
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			count_r <= 8'h00;
			skip_r <= 1'b1;
			use_duty_r <= 1'b0;
		end else if (!count_run_bit) begin
			count_r <= 8'h00;
			skip_r <= 1'b1;
			use_duty_r <= 1'b0;
		end else if (tick) begin
			skip_r <= 1'b0;
			if (skip_r) begin
				count_r <= 8'h00;
			end else if (hit) begin
				if (mode != MODE_INTERVAL)
					use_duty_r <= !use_duty_r;
				if (mode == MODE_PWM && use_duty_r)
					count_r <= count_r + 8'h01;
				else
					count_r <= 8'h00;
			end else begin
				count_r <= count_r + 8'h01;
			end
		end
	end

	// Match interrupt pulse; never raised on a PWM duty match
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			match_interrupt <= 1'b0;
		end else if (!count_run_bit) begin
			match_interrupt <= 1'b0;
		end else begin
			match_interrupt <= tick && hit && !(mode == MODE_PWM && use_duty_r);
		end
	end

	// Square wave, PWM level and carrier clock
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			out_r <= 1'b0;
			carrier_r <= 1'b0;
		end else if (!count_run_bit) begin
			out_r <= 1'b0;
			carrier_r <= 1'b0;
		end else if (tick && hit) begin
			if (mode == MODE_PWM)
				out_r <= !use_duty_r;
			else
				out_r <= !out_r;
			carrier_r <= !carrier_r;
		end
	end

	// Partner interrupt: two-stage synchroniser then count-clock strobe
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			part_s1_r <= 1'b0;
			part_s2_r <= 1'b0;
		end else begin
			part_s1_r <= partner_counter_interrupt;
			part_s2_r <= part_s1_r;
		end
	end

	// Strobe is internal only; it feeds the gate transfer, no interrupt
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			part_cc_r <= 1'b0;
			strobe_r <= 1'b0;
		end else if (tick) begin
			part_cc_r <= part_s2_r;
			strobe_r <= part_s2_r && !part_cc_r;
		end
	end

	// Transfer of staged gate into active gate two count clocks later
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			xfer_r <= 2'h0;
			active_gate_bit <= CARRIER_RST[ACTIVE_BIT];
		end else if (tick) begin
			xfer_r <= {xfer_r[0], strobe_r};
			if (xfer_r[0])
				active_gate_bit <= staged_gate_bit;
		end
	end

	// Pin drive: carrier mode per gate and remote enable; else level bit when stopped or disabled, else out xor level bit
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			timer_output_pin <= 1'b0;
		end else if (mode == MODE_CARRIER) begin
			if (!active_gate_bit)
				timer_output_pin <= 1'b0;
			else if (!remote_output_enable)
				timer_output_pin <= 1'b1;
			else
				timer_output_pin <= carrier_r;
		end else if (!mode_r[OUTEN_BIT]) begin
			timer_output_pin <= mode_r[LEVEL_BIT];
		end else begin
			timer_output_pin <= out_r ^ mode_r[LEVEL_BIT];
		end
	end
endmodule : carrier_timer

// ==== verif/carrier_timer_checker.sv ====
// Port assertions for the carrier timer
`timescale 1ns/1ps
module carrier_timer_checker
	import carrier_timer_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic timer_output_pin,
	input wire logic match_interrupt
);
	logic wr;
	logic [7:0] mode_r;
	logic [7:0] period_r;
	logic [7:0] duty_r;
	logic [16:0] gap_r;
	logic [16:0] hi_r;
	logic [1:0] vcnt_r;
	logic [1:0] quiet_r;
	logic [1:0] md;
	assign wr = psel && penable && pready && pwrite;
	assign md = mode_r[MODE_HI:MODE_LO];
	// Shadow settings, match spacing, high width and settle counts
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mode_r <= MODE_RST;
			period_r <= PERIOD_RST;
			duty_r <= DUTY_RST;
			gap_r <= '0;
			hi_r <= '0;
			vcnt_r <= '0;
			quiet_r <= '0;
		end else begin
			if (wr && paddr == MODE_OFF) mode_r <= pwdata[7:0];
			if (wr && paddr == PERIOD_OFF) period_r <= pwdata[7:0];
			if (wr && paddr == DUTY_OFF) duty_r <= pwdata[7:0];
			gap_r <= match_interrupt ? 17'h0_0001 : gap_r + 17'h0_0001;
			hi_r <= timer_output_pin ? hi_r + 17'h0_0001 : '0;
			if (wr && paddr <= DUTY_OFF) vcnt_r <= '0;
			else if (match_interrupt && vcnt_r != 2'h3) vcnt_r <= vcnt_r + 2'h1;
			if (wr && paddr == MODE_OFF) quiet_r <= '0;
			else if (!mode_r[RUN_BIT] && quiet_r != 2'h3) quiet_r <= quiet_r + 2'h1;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_answer;
		psel && penable && pready;
	endsequence
	property p_ready;
		s_setup |=> s_answer;
	endproperty
	a_ready: assert property (p_ready) else $error("setup not answered");
	property p_pulse;
		match_interrupt |=> !match_interrupt;
	endproperty
	a_pulse: assert property (p_pulse) else $error("match pulse too long");
	property p_stop_irq;
		quiet_r == 2'h3 |-> !match_interrupt;
	endproperty
	a_stop_irq: assert property (p_stop_irq) else $error("match while stopped");
	property p_stop_pin;
		quiet_r == 2'h3 && md != MODE_CARRIER |-> timer_output_pin == mode_r[LEVEL_BIT];
	endproperty
	a_stop_pin: assert property (p_stop_pin) else $error("pin not default");
	property p_gap;
		match_interrupt && vcnt_r == 2'h3 && md != MODE_CARRIER && mode_r[CKS_HI:CKS_LO] == 3'h0
			|-> gap_r == 17'(period_r) + 17'h0_0001;
	endproperty
	a_gap: assert property (p_gap) else $error("match spacing wrong");
	property p_duty;
		$fell(timer_output_pin) && vcnt_r == 2'h3 && md == MODE_PWM
			|-> hi_r == 17'(duty_r) + 17'h0_0001;
	endproperty
	a_duty: assert property (p_duty) else $error("pwm high width wrong");
	property p_start;
		$rose(mode_r[RUN_BIT]) && mode_r[CKS_HI:CKS_LO] == 3'h0 |-> ##[1:300] match_interrupt;
	endproperty
	a_start: assert property (p_start) else $error("count did not start");
	property p_pwm_idle;
		$rose(mode_r[RUN_BIT]) && md == MODE_PWM |-> (timer_output_pin == mode_r[LEVEL_BIT]) [*2];
	endproperty
	a_pwm_idle: assert property (p_pwm_idle) else $error("pwm active too soon");
endmodule : carrier_timer_checker
bind carrier_timer carrier_timer_checker i_carrier_timer_checker (.mclk(mclk), .rst(rst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .timer_output_pin(timer_output_pin), .match_interrupt(match_interrupt));

// ==== verif/ir_link_model.sv ====
// Partner counter stand-in that raises the gating interrupt
`timescale 1ns/1ps
module ir_link_model (
	input wire logic mclk,
	input wire logic rst,
	input wire logic go,
	output logic partner_counter_interrupt
);
	logic [3:0] hold_r;
	// Each request holds the line high for eight clocks, slow beside the count clock
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) hold_r <= 4'h0;
		else if (go) hold_r <= 4'h8;
		else if (hold_r != 4'h0) hold_r <= hold_r - 4'h1;
	end
	assign partner_counter_interrupt = hold_r != 4'h0;
endmodule : ir_link_model

// ==== verif/timer_h_pwm_carrier_output_tb.sv ====
// Self-checking bench of the carrier timer
`timescale 1ns/1ps
module timer_h_pwm_carrier_output_tb;
	import carrier_timer_pkg::*;
	logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, go = 0, e, pin, irq, gate;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, q;
	logic pready, pslverr;
	int n_mismatch = 0, n_checks = 0, cyc = 0, seed = 70873, n, m, s, hi, lo;
	carrier_timer i_carrier_timer (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .partner_counter_interrupt(gate), .timer_output_pin(pin),
		.match_interrupt(irq));
	ir_link_model i_ir_link_model (.mclk(mclk), .rst(rst), .go(go), .partner_counter_interrupt(gate));
	always #2.5 mclk = ~mclk;
	// Cycle ceiling well above the longest planned run
	always @(posedge mclk) if (++cyc == 90000) begin
		n_mismatch++;
		conclude();
	end
	task conclude;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : conclude
	task cmp(input logic [31:0] a, input logic [31:0] x);
		n_checks++;
		if (a !== x) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, a, x);
		end
	endtask : cmp
	// One APB transfer, held until pready is sampled high
	task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1;
		// Look between edges so the registered answer is settled, then close at the edge
		@(negedge mclk);
		while (pready !== 1'b1) @(negedge mclk);
		q = prdata;
		e = pslverr;
		@(posedge mclk);
		psel <= 0;
		penable <= 0;
	endtask : apb
	// Widths of one full high and low phase of the pin
	task measure;
		@(negedge mclk);
		while (pin !== 1'b0) @(negedge mclk);
		while (pin !== 1'b1) @(negedge mclk);
		for (hi = 0; pin === 1'b1; hi++) @(negedge mclk);
		for (lo = 0; pin === 1'b0; lo++) @(negedge mclk);
	endtask : measure
	task pulse;
		go <= 1;
		@(posedge mclk);
		go <= 0;
	endtask : pulse
	function logic [31:0] mv(input int sl, input logic [1:0] md);
		return 32'h0000_0081 | (sl << CKS_LO) | (md << MODE_LO);
	endfunction : mv
	initial begin
		repeat (5) @(posedge mclk);
		rst <= 0;
		// Reset values, then an unmapped word
		for (s = 0; s <= 'h14; s += 4) begin
			apb(12'(s), 0, 0);
			cmp(q, 0);
			cmp(e, s == 'h14);
		end
		apb(CARRIER_OFF, 1, 7);
		apb(CARRIER_OFF, 0, 0);
		cmp(q, 6);
		$display("register test done");
		// Interval mode at four count clock rates
		for (s = 0; s < 4; s++) begin
			n = ($random(seed) & 63) + 1;
			apb(PERIOD_OFF, 1, n);
			apb(MODE_OFF, 1, mv(s, MODE_INTERVAL));
			measure;
			cmp(hi, (n + 1) << (2 * s));
			cmp(lo, (n + 1) << (2 * s));
			apb(MODE_OFF, 1, mv(s, MODE_INTERVAL) ^ 32'h0000_0080);
			repeat (3) @(posedge mclk);
			cmp({irq, pin}, 0);
		end
		$display("interval test done");
		// PWM, then a duty change while running
		n = ($random(seed) & 63) + 2;
		m = $unsigned($random(seed)) % n;
		apb(DUTY_OFF, 1, m);
		apb(PERIOD_OFF, 1, n);
		apb(MODE_OFF, 1, mv(0, MODE_PWM));
		measure;
		cmp(hi, m + 1);
		cmp(hi + lo, n + 1);
		m = $unsigned($random(seed)) % n;
		apb(DUTY_OFF, 1, m);
		repeat (3 * n + 6) @(posedge mclk);
		measure;
		cmp(hi, m + 1);
		apb(MODE_OFF, 1, mv(0, MODE_PWM) ^ 32'h0000_0080);
		repeat (3) @(posedge mclk);
		cmp({irq, pin}, 0);
		$display("pwm test done");
		// Carrier gated by the partner interrupt
		n = ($random(seed) & 31) + 1;
		m = ($random(seed) & 31) + 1;
		apb(DUTY_OFF, 1, m);
		apb(PERIOD_OFF, 1, n);
		apb(MODE_OFF, 1, mv(0, MODE_CARRIER));
		pulse;
		apb(CARRIER_OFF, 0, 0);
		cmp(q, 6);
		repeat (20) @(posedge mclk);
		apb(CARRIER_OFF, 0, 0);
		cmp(q, 7);
		measure;
		cmp(hi, m + 1);
		cmp(lo, n + 1);
		apb(CARRIER_OFF, 1, 4);
		pulse;
		repeat (n + m + 24) @(posedge mclk);
		cmp(pin, 0);
		apb(MODE_OFF, 1, mv(0, MODE_CARRIER) ^ 32'h0000_0080);
		apb(CARRIER_OFF, 1, 2);
		apb(DUTY_OFF, 1, m);
		apb(MODE_OFF, 1, mv(0, MODE_CARRIER));
		pulse;
		repeat (n + m + 24) @(posedge mclk);
		cmp(pin, 1);
		$display("carrier test done");
		conclude();
	end
endmodule : timer_h_pwm_carrier_output_tb
